// >>> rtl/ulms_pkg.sv
package ulms_pkg;
  // ---------------------------------------------------------------
  // Register offsets on the host register port
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA         = 3'h0;
  localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS  = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;

  // ---------------------------------------------------------------
  // modem_control field positions and reset value
  // ---------------------------------------------------------------
  localparam int MC_DTR   = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_AUX1  = 2;
  localparam int MC_AUX2  = 3;
  localparam int MC_LOOP  = 4;
  localparam int MC_XANY  = 5;
  localparam int MC_IR    = 6;
  localparam int MC_PRESC = 7;
  localparam logic [7:0] MC_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Prescaler and buffer figures
  // ---------------------------------------------------------------
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam int FIFO_DEPTH_DEF = 64;

  // Break capture state: one break character per break condition.
  typedef enum logic [0:0] {
    ULMS_BRK_ARMED = 1'b0,
    ULMS_BRK_HELD  = 1'b1
  } ulms_brk_t;
endpackage

// >>> rtl/ulms_core.sv
// What this block does
// [RULE1] Loopback bit set selects local loopback
// [RULE2] Resume-any writable only when enhanced; resumes
// [RULE3] Resume-any stores chars except Xon/Xoff
// [RULE4] Infrared bit routes serial through codec
// [RULE5] Infrared transmit output idles low
// [RULE6] Prescaler bit enhanced-only; divides clock four
// [RULE7] Data ready while receive storage non-empty
// [RULE8] Full FIFO: set overrun, drop character
// [RULE9] Parity flag belongs to head character
// [RULE10] Framing flag belongs to head character
// [RULE11] Break flag; one break char per break
// [RULE12] Holding empty follows transmit storage emptiness
// [RULE13] Transmitter empty when storage and shifter empty
// [RULE14] FIFO error while any stored byte errored
// [RULE15] Delta CTS/DSR/CD flags; interrupt when enabled
// [RULE16] Delta RI only on ringing end
// [RULE17] Auto CTS high stops after current char
// [RULE18] CTS status inverse pin, loopback RTS
// [RULE19] DSR status inverse pin, loopback DTR
// [RULE20] RI status inverse pin, loopback aux one
// [RULE21] CD status inverse pin, loopback aux two
// [RULE22] RTS/DTR bits drive low-active outputs
// [RULE23] Reading modem status clears delta flags
`timescale 1ns/1ps
module ulms_core #(
  parameter int DEPTH = ulms_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Host register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Configuration levels
  input  wire logic       enh_enable,
  input  wire logic       auto_cts_en,
  input  wire logic       sw_flow_en,
  input  wire logic [7:0] xon_char,
  input  wire logic [7:0] xoff_char,
  input  wire logic       msr_int_en,
  input  wire logic       fifo_en,
  // Received characters from the receive shifter
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_char_perr,
  input  wire logic       rx_char_ferr,
  input  wire logic       rx_char_brk,
  // Transmit characters to the transmit shifter
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  input  wire logic       tx_ready,
  input  wire logic       tx_shift_busy,
  // Serial routing and clock prescale
  input  wire logic       tx_ser,
  input  wire logic       ir_tx_enc,
  input  wire logic       ir_rx_dec,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            rx_ser,
  output logic            baud_tick,
  // Modem lines and status
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  output logic            rts_n,
  output logic            dtr_n,
  output logic            modem_int,
  output logic            tx_halted
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("DEPTH must be a power of two of at least 2");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  logic [7:0] mcr_r;
  logic       wr_data, rd_data, wr_mcr, rd_lsr, rd_msr;
  assign wr_data = reg_wr && reg_addr == ulms_pkg::ADDR_DATA;
  assign rd_data = reg_rd && reg_addr == ulms_pkg::ADDR_DATA;
  assign wr_mcr  = reg_wr && reg_addr == ulms_pkg::ADDR_MODEM_CONTROL;
  assign rd_lsr  = reg_rd && reg_addr == ulms_pkg::ADDR_LINE_STATUS;
  assign rd_msr  = reg_rd && reg_addr == ulms_pkg::ADDR_MODEM_STATUS;

  // Modem control; locked bits keep their value unless enhanced.
  // [RULE2] [RULE6] enhanced write gate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mcr_r <= ulms_pkg::MC_RESET;
    end else if (wr_mcr) begin
      mcr_r <= reg_wdata;
      if (!enh_enable) begin
        mcr_r[ulms_pkg::MC_XANY]  <= mcr_r[ulms_pkg::MC_XANY];
        mcr_r[ulms_pkg::MC_PRESC] <= mcr_r[ulms_pkg::MC_PRESC];
      end
    end
  end

  logic       loop_on, ir_on;
  logic [3:0] ms_now;
  // [RULE1] loopback mode select
  assign loop_on = mcr_r[ulms_pkg::MC_LOOP];
  assign ir_on   = mcr_r[ulms_pkg::MC_IR];

  // ---------------------------------------------------------------
  // Serial routing and prescaler
  // ---------------------------------------------------------------
  // Loopback holds the line pin at mark so the far end sees idle.
  // [RULE4] [RULE5] infrared routing and idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_pin <= 1'b1;
      rx_ser <= 1'b1;
    end else begin
      if (loop_on) tx_pin <= 1'b1;
      else if (ir_on) tx_pin <= ir_tx_enc & tx_shift_busy;
      else tx_pin <= tx_ser;
      if (loop_on) rx_ser <= tx_ser;
      else if (ir_on) rx_ser <= ir_rx_dec;
      else rx_ser <= rx_pin;
    end
  end
  logic [1:0] presc_r;
  // [RULE6] divide by one or four
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_r   <= 2'h0;
      baud_tick <= 1'b0;
    end else begin
      presc_r   <= presc_r + 2'h1;
      baud_tick <= !mcr_r[ulms_pkg::MC_PRESC] ||
                   presc_r == ulms_pkg::PRESC_LAST;
    end
  end

  // ---------------------------------------------------------------
  // Receive path: filter, break capture, flow halt
  // ---------------------------------------------------------------
  ulms_pkg::ulms_brk_t brk_r;
  logic is_flow, keep_char, sw_halt_r;
  assign is_flow = sw_flow_en &&
                   (rx_char_data == xon_char || rx_char_data == xoff_char);
  // [RULE3] [RULE11] flow chars and repeat breaks dropped
  assign keep_char = rx_char_valid && !is_flow &&
                     !(rx_char_brk && brk_r == ulms_pkg::ULMS_BRK_HELD);
  // A break re-arms only once the line has returned to mark.
  // [RULE11] one break per condition
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brk_r <= ulms_pkg::ULMS_BRK_ARMED;
    end else begin
      case (brk_r)
        ulms_pkg::ULMS_BRK_ARMED:
          if (rx_char_valid && rx_char_brk) brk_r <= ulms_pkg::ULMS_BRK_HELD;
        ulms_pkg::ULMS_BRK_HELD:
          if (rx_ser) brk_r <= ulms_pkg::ULMS_BRK_ARMED;
        default: brk_r <= ulms_pkg::ULMS_BRK_ARMED;
      endcase
    end
  end
  // Xoff halts; Xon, or any character in resume-any mode, restarts.
  // [RULE2] any character resumes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_halt_r <= 1'b0;
    end else if (rx_char_valid) begin
      if (sw_flow_en && rx_char_data == xoff_char) sw_halt_r <= 1'b1;
      else if (is_flow || mcr_r[ulms_pkg::MC_XANY]) sw_halt_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO with error tags {brk, ferr, perr, data}
  // ---------------------------------------------------------------
  logic [10:0]   rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_r, rx_rp_r;
  logic [CW-1:0] rx_cnt_r, rx_err_r;
  logic          rx_full, rx_pop, rx_push, oe_r, push_err, pop_err;
  logic [10:0]   rx_head;
  // Without FIFO mode a single holding stage is used.
  assign rx_full  = fifo_en ? rx_cnt_r == CW'(DEPTH) : rx_cnt_r != '0;
  assign rx_pop   = rd_data && rx_cnt_r != '0;
  // [RULE8] no push while full, except in a pop cycle
  assign rx_push  = keep_char && (!rx_full || rx_pop);
  assign rx_head  = rx_cnt_r != '0 ? rx_mem[rx_rp_r] : 11'h000;
  assign push_err = rx_char_perr | rx_char_ferr | rx_char_brk;
  assign pop_err  = |rx_head[10:8];

  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp_r] <= {rx_char_brk, rx_char_ferr,
                                      rx_char_perr, rx_char_data};
  end
  // Pointers, occupancy and count of errored entries.
  // [RULE14] errored entry count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
      rx_err_r <= '0;
    end else begin
      if (rx_push) rx_wp_r <= rx_wp_r + AW'(1);
      if (rx_pop) rx_rp_r <= rx_rp_r + AW'(1);
      rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
      rx_err_r <= rx_err_r + CW'(rx_push && push_err) -
                  CW'(rx_pop && pop_err);
    end
  end
  // Overrun is sticky until the line status is read; a new overrun
  // in the read cycle wins so it is never lost.
  // [RULE8] overrun flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) oe_r <= 1'b0;
    else oe_r <= (oe_r && !rd_lsr) || (keep_char && rx_full && !rx_pop);
  end

  // ---------------------------------------------------------------
  // Transmit FIFO and two-entry output buffer
  // ---------------------------------------------------------------
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_rp_r;
  logic [CW-1:0] tx_cnt_r;
  logic [7:0]    b0_r, b1_r, b0_nxt, b1_nxt;
  logic [1:0]    bv_r, bv_nxt;
  logic          tx_full, tx_push, tx_pop, take, stop;
  assign tx_full = fifo_en ? tx_cnt_r == CW'(DEPTH) : tx_cnt_r != '0;
  assign tx_push = wr_data && !tx_full;
  assign tx_pop  = tx_cnt_r != '0 && !bv_r[1];
  assign take    = tx_valid && tx_ready;
  // [RULE17] CTS high or Xoff stops
  assign stop    = sw_halt_r || (auto_cts_en && !ms_now[0]);
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp_r] <= reg_wdata;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) tx_wp_r <= tx_wp_r + AW'(1);
      if (tx_pop) tx_rp_r <= tx_rp_r + AW'(1);
      tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
    end
  end
  // Shift out on a taken word, then load into the first free slot.
  always_comb begin
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    bv_nxt = bv_r;
    if (take) begin
      b0_nxt = b1_r;
      bv_nxt = {1'b0, bv_r[1]};
    end
    if (tx_pop) begin
      if (!bv_nxt[0]) begin
        b0_nxt    = tx_mem[tx_rp_r];
        bv_nxt[0] = 1'b1;
      end else begin
        b1_nxt    = tx_mem[tx_rp_r];
        bv_nxt[1] = 1'b1;
      end
    end
  end
  // Stop only withholds the next word; one already taken finishes.
  // [RULE17] transmit gating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      b0_r      <= 8'h00;
      b1_r      <= 8'h00;
      bv_r      <= 2'h0;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      tx_halted <= 1'b0;
    end else begin
      b0_r      <= b0_nxt;
      b1_r      <= b1_nxt;
      bv_r      <= bv_nxt;
      tx_valid  <= bv_nxt[0] && !stop;
      tx_data   <= b0_nxt;
      tx_halted <= stop;
    end
  end

  // ---------------------------------------------------------------
  // Modem status: levels {cd, ri, dsr, cts} and deltas
  // ---------------------------------------------------------------
  logic [3:0] ms_r, dl_r, dl_set;
  // [RULE18] [RULE19] [RULE20] [RULE21] loopback substitution
  assign ms_now = loop_on ? {mcr_r[ulms_pkg::MC_AUX2],
                             mcr_r[ulms_pkg::MC_AUX1],
                             mcr_r[ulms_pkg::MC_DTR],
                             mcr_r[ulms_pkg::MC_RTS]}
                          : ~{cd_n, ri_n, dsr_n, cts_n};
  // [RULE15] [RULE16] change detection
  assign dl_set = {ms_r[3] ^ ms_now[3], ms_r[2] & ~ms_now[2],
                   ms_r[1] ^ ms_now[1], ms_r[0] ^ ms_now[0]};

  // A change in the read cycle survives the clear.
  // [RULE23] read clears deltas
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_r      <= 4'h0;
      dl_r      <= 4'h0;
      modem_int <= 1'b0;
      rts_n     <= 1'b1;
      dtr_n     <= 1'b1;
    end else begin
      ms_r      <= ms_now;
      dl_r      <= (rd_msr ? 4'h0 : dl_r) | dl_set;
      modem_int <= msr_int_en && |((rd_msr ? 4'h0 : dl_r) | dl_set);
      // [RULE22] low-active modem outputs
      rts_n     <= !mcr_r[ulms_pkg::MC_RTS];
      dtr_n     <= !mcr_r[ulms_pkg::MC_DTR];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] line_status;
  logic       thre, temt;
  // [RULE12] holding empty
  assign thre = tx_cnt_r == '0;
  // [RULE13] transmitter fully idle
  assign temt = thre && bv_r == 2'h0 && !tx_shift_busy;
  // [RULE7] [RULE9] [RULE10] [RULE14] line status
  assign line_status  = {rx_err_r != '0, temt, thre, rx_head[10], rx_head[9],
                 rx_head[8], oe_r, rx_cnt_r != '0};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ulms_pkg::ADDR_DATA:          reg_rdata <= rx_head[7:0];
        ulms_pkg::ADDR_MODEM_CONTROL: reg_rdata <= mcr_r;
        ulms_pkg::ADDR_LINE_STATUS:   reg_rdata <= line_status;
        ulms_pkg::ADDR_MODEM_STATUS:  reg_rdata <= {ms_r, dl_r};
        default:                      reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_loop_cts: assert property ( // [RULE18]
    loop_on |=> ms_r[0] == $past(mcr_r[ulms_pkg::MC_RTS]))
    else $error("loopback CTS level wrong");
  chk_lock_bits: assert property ( // [RULE2]
    wr_mcr && !enh_enable |=> $stable(mcr_r[ulms_pkg::MC_XANY]) &&
                              $stable(mcr_r[ulms_pkg::MC_PRESC]))
    else $error("locked control bit changed");
  chk_ir_idle: assert property ( // [RULE5]
    ir_on && !loop_on && !tx_shift_busy |=> !tx_pin)
    else $error("infrared output not idle low");
  chk_presc_gap: assert property ( // [RULE6]
    mcr_r[ulms_pkg::MC_PRESC] && $past(mcr_r[ulms_pkg::MC_PRESC], 4)
      && baud_tick |-> !$past(baud_tick) && !$past(baud_tick, 2))
    else $error("prescaled tick too close");
  chk_ready_flag: assert property ( // [RULE7]
    reg_rd && reg_addr == ulms_pkg::ADDR_LINE_STATUS |=>
      reg_rdata[0] == ($past(rx_cnt_r) != '0))
    else $error("data ready flag wrong");
  chk_overrun_set: assert property ( // [RULE8]
    keep_char && rx_full && !rx_pop |=> oe_r && $stable(rx_cnt_r))
    else $error("overrun not flagged");
  chk_thre_load: assert property ( // [RULE12]
    tx_push |=> !thre) else $error("holding empty after load");
  chk_temt_busy: assert property ( // [RULE13]
    tx_shift_busy |-> !temt) else $error("empty while shifting");
  chk_ri_edge: assert property ( // [RULE16]
    !rd_msr && !dl_r[2] && !(ms_r[2] && !ms_now[2]) |=> !dl_r[2])
    else $error("delta RI on wrong edge");
  chk_cts_stop: assert property ( // [RULE17]
    auto_cts_en && !ms_now[0] |=> !tx_valid) else $error("CTS stop ignored");
  chk_rts_drive: assert property ( // [RULE22]
    ##1 $stable(mcr_r) |-> rts_n == !mcr_r[ulms_pkg::MC_RTS])
    else $error("RTS output wrong");
  chk_delta_clear: assert property ( // [RULE23]
    rd_msr && dl_set == 4'h0 |=> dl_r == 4'h0) else $error("delta kept");

  cov_overrun: cover property (keep_char && rx_full);
  cov_break_once: cover property (rx_char_valid && rx_char_brk ##1
                                  rx_char_valid && rx_char_brk);
  cov_cts_halt: cover property (tx_valid ##1 tx_halted);
  cov_ri_end: cover property (dl_set[2]);
endmodule

// >>> tb/ulms_far_end.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far-end transmit shifter model
// ---------------------------------------------------------------
module ulms_far_end #(
  parameter int BUSY_LEN = 5
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Words offered by the block
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       stall,
  output logic            tx_ready,
  output logic            tx_shift_busy,
  output logic            tx_ser,
  // Report of each accepted word
  output logic            got,
  output logic      [7:0] got_data
);
  int cnt;

  // Slow on purpose: one word at a time, and none while stalled.
  assign tx_ready      = !stall && cnt == 0;
  assign tx_shift_busy = cnt != 0;
  // An idle line rests high; a busy line shows the data bit picked by the count's low three bits, xored with the count's low bit.
  assign tx_ser = (cnt == 0) ? 1'b1 : (got_data[cnt[2:0]] ^ cnt[0]);

  // Take a word and stay busy while it shifts out.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt      <= 0;
      got      <= 1'b0;
      got_data <= 8'h00;
    end else begin
      got <= tx_valid && tx_ready;
      if (tx_valid && tx_ready) begin
        cnt      <= BUSY_LEN;
        got_data <= tx_data;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// >>> tb/ulms_core_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
  failures++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module ulms_core_test;
  localparam int DEPTH = 4;
  logic       clk, resetn, reg_wr, reg_rd, enh_enable, auto_cts_en;
  logic       sw_flow_en, msr_int_en, fifo_en, rx_char_valid, rx_char_perr;
  logic       rx_char_ferr, rx_char_brk, tx_ready, tx_shift_busy, tx_ser;
  logic       ir_tx_enc, ir_rx_dec, rx_pin, cts_n, dsr_n, ri_n, cd_n;
  logic       tx_valid, tx_pin, rx_ser, baud_tick, rts_n, dtr_n;
  logic       modem_int, tx_halted, stall, got, ovr, held;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_char_data, tx_data, got_data, d;
  logic [7:0] xon_char, xoff_char;
  logic [3:0] lv, dl, bt;
  logic [7:0] wv[3];
  logic [11:0] lb[2] = '{12'he1d, 12'h91a};
  logic [10:0] q[$];
  int         failures, n_checks, n;

  ulms_core #(.DEPTH(DEPTH)) i_ulms_core (.*);
  ulms_far_end i_ulms_far_end (.*);

  // Free-running bench clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Register writes and reads hold the strobe for exactly one edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask

  // Line status expected from the receive queue model and transmit state.
  task automatic ck_ls(input logic [1:0] tx);
    logic [10:0] h;
    logic        e;
    logic [7:0]  x;
    h = (q.size() > 0) ? q[0] : 11'h000;
    e = 1'b0;
    foreach (q[i]) e |= |q[i][10:8];
    x = {e, tx, h[10:8], ovr, q.size() > 0};
    rd(3'h5);
    `CHK("line_status", x, d)
    ovr = 1'b0;
  endtask

  // Offer one received character; the model decides whether it is kept.
  task automatic rxc(input logic [7:0] v, input logic [2:0] e);
    logic keep;
    keep = !(sw_flow_en && (v == xon_char || v == xoff_char));
    keep = keep && !(e[2] && held);
    if (keep && q.size() == DEPTH) ovr = 1'b1;
    else if (keep) q.push_back({e, v});
    if (e[2]) held = !rx_pin;
    rx_char_data = v;
    {rx_char_brk, rx_char_ferr, rx_char_perr} = e;
    rx_char_valid = 1'b1;
    tick(1);
    rx_char_valid = 1'b0;
    tick(1);
  endtask

  task automatic rdd();
    rd(3'h0);
    `CHK("rx data", q[0][7:0], d)
    void'(q.pop_front());
  endtask

  // Modem pins change; the model tracks levels and delta flags.
  task automatic pins(input logic [3:0] p);
    logic [3:0] nl;
    nl = ~p;
    dl |= (nl ^ lv) & 4'hb;
    dl[2] |= lv[2] & ~nl[2];
    lv = nl;
    {cd_n, ri_n, dsr_n, cts_n} = p;
  endtask

  // Wait, bounded, for the far end to accept the next word.
  task automatic take(input logic [7:0] v);
    for (int k = 0; k < 200 && got !== 1'b1; k++) tick(1);
    if (got !== 1'b1) begin
      failures++;
      tally_and_finish();
    end else begin
      `CHK("tx word", v, got_data)
      tick(1);
    end
  endtask

  // Main sequence: reset, then one test per feature group.
  initial begin
    {reg_wr, reg_rd, enh_enable, auto_cts_en, sw_flow_en} = '0;
    {msr_int_en, rx_char_valid, rx_char_perr, rx_char_ferr} = '0;
    {rx_char_brk, ir_tx_enc, ir_rx_dec, stall, resetn} = '0;
    {cts_n, dsr_n, ri_n, cd_n, rx_pin, fifo_en} = '1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    rx_char_data = 8'h00;
    xon_char = 8'h11;
    xoff_char = 8'h13;
    {lv, dl, ovr, held} = '0;
    failures = 0;
    n_checks = 0;
    n = $urandom(81);
    tick(8);
    resetn = 1'b1;
    tick(1);
    rd(3'h4);
    `CHK("modem_control", 8'h00, d)
    `CHK("rts dtr idle", 2'b11, {rts_n, dtr_n})
    rd(3'h7);
    `CHK("unmapped", 8'h00, d)
    wr(3'h4, 8'ha3);
    rd(3'h4);
    `CHK("masked write", 8'h03, d)
    `CHK("rts dtr on", 2'b00, {rts_n, dtr_n})
    enh_enable = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(3'h4, {s[0], 7'h00});
      bt = 4'h0;
      repeat (8) begin
        tick(1);
        bt += {3'h0, baud_tick};
      end
      `CHK("baud ticks", s ? 4'h2 : 4'h8, bt)
    end
    done("controls");
    for (int i = 0; i < 6; i++) begin
      msr_int_en = 1'($urandom);
      pins(i == 0 ? 4'h0 : i == 1 ? 4'hf : 4'($urandom));
      tick(3);
      `CHK("modem_int", msr_int_en & |dl, modem_int)
      rd(3'h6);
      `CHK("modem_status", {lv, dl}, d)
      dl = 4'h0;
    end
    foreach (lb[i]) begin
      wr(3'h4, lb[i][7:0]);
      tick(2);
      rd(3'h6);
      `CHK("loop cts dsr", lb[i][9:8], d[5:4])
      `CHK("loop ri cd", lb[i][11:10], d[7:6])
      `CHK("loop tx_pin", 1'b1, tx_pin)
      `CHK("loop rx_ser", tx_ser, rx_ser)
    end
    wr(3'h4, 8'h00);
    tick(2);
    rd(3'h6);
    dl = 4'h0;
    done("modem");
    repeat (6) rxc(8'($urandom), {1'b0, 2'($urandom)});
    ck_ls(2'b11);
    while (q.size() > 0) begin
      rdd();
      ck_ls(2'b11);
    end
    rx_pin = 1'b0;
    tick(3);
    repeat (2) rxc(8'h00, 3'b110);
    rx_pin = 1'b1;
    tick(3);
    held = 1'b0;
    rxc(8'h00, 3'b100);
    ck_ls(2'b11);
    while (q.size() > 0) begin
      rdd();
      ck_ls(2'b11);
    end
    done("receive");
    sw_flow_en = 1'b1;
    rxc(xoff_char, 3'b000);
    tick(1);
    `CHK("halt on xoff", 1'b1, tx_halted)
    wr(3'h4, 8'h20);
    rxc(8'h41, 3'b000);
    tick(1);
    `CHK("resume any", 1'b0, tx_halted)
    rxc(xon_char, 3'b000);
    ck_ls(2'b11);
    rdd();
    sw_flow_en = 1'b0;
    wr(3'h4, 8'h00);
    done("flow");
    stall = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wv[i] = 8'($urandom);
      wr(3'h0, wv[i]);
      if (i != 1) begin
        tick(4);
        ck_ls(i == 0 ? 2'b01 : 2'b00);
      end
    end
    stall = 1'b0;
    for (int i = 0; i < 3; i++) take(wv[i]);
    tick(8);
    ck_ls(2'b11);
    auto_cts_en = 1'b1;
    pins(4'h1);
    wr(3'h0, 8'h5a);
    tick(6);
    `CHK("cts stop", 2'b01, {tx_valid, tx_halted})
    pins(4'h0);
    take(8'h5a);
    auto_cts_en = 1'b0;
    done("transmit");
    wr(3'h4, 8'h40);
    ir_tx_enc = 1'b1;
    for (int i = 0; i < 2; i++) begin
      ir_rx_dec = i[0];
      tick(3);
      `CHK("ir tx idle", 1'b0, tx_pin)
      `CHK("ir rx path", i[0], rx_ser)
    end
    wr(3'h4, 8'h00);
    tick(2);
    `CHK("std tx path", tx_ser, tx_pin)
    done("infrared");
    tally_and_finish();
  end
endmodule
